// ===== core/ilpd_pkg.sv
package ilpd_pkg;

	// Register byte addresses on the APB window.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_LEARN_LEN = 8'h08;
	localparam logic [7:0] ADDR_DETECT_LEN = 8'h0C;
	localparam logic [7:0] ADDR_MIN_SD = 8'h10;
	localparam logic [7:0] ADDR_SD_LO = 8'h14;
	localparam logic [7:0] ADDR_SD_HI = 8'h18;
	localparam logic [7:0] ADDR_MEAN_TOL = 8'h1C;
	localparam logic [7:0] ADDR_VAR_TOL = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	// Field positions.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_AFFECT_BIT = 1;
	localparam int CTRL_DP_BIT = 2;
	localparam int CMD_RELEARN_BIT = 0;
	localparam int STAT_DIAG_LSB = 0;
	localparam int STAT_ALERT_BIT = 3;
	localparam int STAT_CALC_BIT = 4;
	localparam int STAT_PHASE_LSB = 8;

	// The time base delivers one tick per second.
	localparam int TICKS_PER_SEC = 1;
	localparam int SEC_PER_MIN = 60;
	localparam int LEARN_PERIOD_MIN = 5;
	localparam int DETECT_PERIOD_MIN = 1;
	localparam int LEARN_TICKS = LEARN_PERIOD_MIN * SEC_PER_MIN * TICKS_PER_SEC;
	localparam int DETECT_TICKS = DETECT_PERIOD_MIN * SEC_PER_MIN * TICKS_PER_SEC;

	// Reset values of the sensitivity settings, in sample units; VAR_TOL_RST is in squared sample units.
	localparam int MIN_SD_RST = 4;
	localparam int SD_LO_RST = 2;
	localparam int SD_HI_RST = 1024;
	localparam int MEAN_TOL_RST = 256;
	localparam int VAR_TOL_RST = 4096;

	// Status quality code forced on the pressure value.
	localparam logic [1:0] QUAL_UNCERTAIN = 2'h1;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_LEARN = 3'b001,
		PH_VERIFY = 3'b010,
		PH_DETECT = 3'b011,
		PH_HALT_DYN = 3'b100,
		PH_HALT_PLUG = 3'b101
	} ilpd_phase_type;

	typedef enum logic [2:0] {
		DG_DISABLED = 3'b000,
		DG_LEARNING = 3'b001,
		DG_VERIFYING = 3'b010,
		DG_OK = 3'b011,
		DG_INSUFFICIENT = 3'b100,
		DG_LINES_PLUGGED = 3'b101
	} ilpd_diag_type;

endpackage : ilpd_pkg

// ===== core/ilpd_stats.sv
module ilpd_stats
	import ilpd_pkg::*;
#(
	parameter int DW = 16,
	parameter int CW = 24
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Control.
	input wire logic clear,
	input wire logic finish,
	// Samples.
	input wire logic sample_valid,
	input wire logic [DW-1:0] sample,
	// Results.
	output logic busy,
	output logic done,
	output logic [DW-1:0] mean,
	output logic [2*DW-1:0] variance
);

	localparam int SQW = 2 * DW + CW;
	localparam logic [7:0] STEPS = 8'(SQW);
	localparam logic [7:0] LAST_STEP = 8'h01;

	typedef struct packed {
		logic [CW-1:0] n;
		logic [SQW-1:0] quo_s;
		logic [SQW-1:0] quo_q;
		logic [CW-1:0] rem_s;
		logic [CW-1:0] rem_q;
		logic [7:0] step;
		logic busy;
		logic done;
	} ilpd_stats_type;

	ilpd_stats_type r;
	ilpd_stats_type next_r;
	logic [CW:0] trial_s;
	logic [CW:0] trial_q;
	logic [2*DW-1:0] ex2;
	logic [2*DW-1:0] msq;

	// Sums accumulate in the quotient registers, which the divider then consumes in place.
	always_comb
	begin
		next_r = r;
		next_r.done = 1'h0;
		trial_s = {r.rem_s, r.quo_s[SQW-1]};
		trial_q = {r.rem_q, r.quo_q[SQW-1]};
		if (!r.busy)
		begin
			if (finish)
			begin
				next_r.busy = 1'h1;
				next_r.step = STEPS;
				next_r.rem_s = '0;
				next_r.rem_q = '0;
			end
			else if (clear)
			begin
				next_r.n = '0;
				next_r.quo_s = '0;
				next_r.quo_q = '0;
			end
			else if (sample_valid)
			begin
				next_r.n = r.n + CW'(1);
				next_r.quo_s = r.quo_s + SQW'(sample);
				next_r.quo_q = r.quo_q + SQW'({{DW{1'h0}}, sample} * {{DW{1'h0}}, sample});
			end
		end
		else
		begin
			if (trial_s >= {1'h0, r.n})
			begin
				next_r.rem_s = CW'(trial_s - {1'h0, r.n});
				next_r.quo_s = {r.quo_s[SQW-2:0], 1'h1};
			end
			else
			begin
				next_r.rem_s = trial_s[CW-1:0];
				next_r.quo_s = {r.quo_s[SQW-2:0], 1'h0};
			end
			if (trial_q >= {1'h0, r.n})
			begin
				next_r.rem_q = CW'(trial_q - {1'h0, r.n});
				next_r.quo_q = {r.quo_q[SQW-2:0], 1'h1};
			end
			else
			begin
				next_r.rem_q = trial_q[CW-1:0];
				next_r.quo_q = {r.quo_q[SQW-2:0], 1'h0};
			end
			next_r.step = r.step - LAST_STEP;
			if (r.step == LAST_STEP)
			begin
				next_r.busy = 1'h0;
				next_r.done = 1'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '0;
		else if (ce)
			r <= next_r;
	end

	// An empty period would divide by zero, so it reports zero mean and variance.
	always_comb
	begin
		mean = (r.n == '0) ? '0 : r.quo_s[DW-1:0];
		ex2 = (r.n == '0) ? '0 : r.quo_q[2*DW-1:0];
		msq = {{DW{1'h0}}, mean} * {{DW{1'h0}}, mean};
		variance = (ex2 > msq) ? (ex2 - msq) : '0;
	end

	assign busy = r.busy;
	assign done = r.done;

endmodule : ilpd_stats

// ===== core/ilpd_top.sv
// Summary of operation
// - Enable with statistics idle, relearn or mean change starts learning.
// - Learning accumulates samples, then mean and deviation.
// - Status reads Learning during learning.
// - Too little deviation sets Insufficient Dynamics, halts.
// - Halted detector waits for a relearn command.
// - Verification repeats collection for learning length.
// - Status reads Verifying during verification.
// - Steady newest versus previous pair advances detection.
// - Unsteady result repeats verification.
// - Input is fixed to the pressure value.
// - Mean and deviation stay internal.
// - Deviation outside limits raises an alert.
// - Alert names a plugged impulse line.
// - Optionally force pressure quality to Uncertain.
// - Learning and detection lengths set independently.
// - Steady verification latches the baseline pair.
// - Detection collects over its own period.
// - Mean shift from baseline returns to learning.
// - Lower limit always, upper only for DP.
//
// Implementation choices: the address map and the APB register port.
module ilpd_top
	import ilpd_pkg::*;
#(
	parameter int DW = 16,
	parameter int CW = 24,
	parameter int PW = 24
)
(
	// Clock, reset and clock enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Time base.
	input wire logic tick,
	// Pressure measurement.
	input wire logic press_valid,
	input wire logic [DW-1:0] press_data,
	input wire logic [1:0] press_quality,
	output logic [1:0] press_quality_out,
	// Diagnostic results.
	output logic plug_alert,
	output logic [2:0] diag_status
);

	typedef struct packed {
		ilpd_phase_type phase;
		ilpd_diag_type diag;
		logic enable;
		logic affect;
		logic dp;
		logic [PW-1:0] learn_len;
		logic [PW-1:0] detect_len;
		logic [DW-1:0] min_sd;
		logic [DW-1:0] sd_lo;
		logic [DW-1:0] sd_hi;
		logic [DW-1:0] mean_tol;
		logic [2*DW-1:0] var_tol;
		logic [PW-1:0] tcount;
		logic calc;
		logic clear;
		logic finish;
		logic [DW-1:0] prev_mean;
		logic [2*DW-1:0] prev_var;
		logic [DW-1:0] base_mean;
		logic [2*DW-1:0] base_var;
		logic plug_alert;
		logic [1:0] qual_out;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ilpd_state_type;

	ilpd_state_type r;
	ilpd_state_type next_r;
	logic st_busy;
	logic st_done;
	logic [DW-1:0] st_mean;
	logic [2*DW-1:0] st_var;
	logic collecting;

	function automatic logic [2*DW-1:0] square(input logic [DW-1:0] a);
		square = {{DW{1'h0}}, a} * {{DW{1'h0}}, a};
	endfunction : square

	function automatic logic [2*DW-1:0] absdiff(input logic [2*DW-1:0] a, input logic [2*DW-1:0] b);
		absdiff = (a > b) ? (a - b) : (b - a);
	endfunction : absdiff

	// Samples count only while a period runs; during the division they are dropped.
	assign collecting = press_valid && !r.calc && !r.finish && !r.clear &&
		(r.phase == PH_LEARN || r.phase == PH_VERIFY || r.phase == PH_DETECT);

	// The statistics never leave the block; only the verdicts do.
	ilpd_stats #(
		.DW(DW),
		.CW(CW)
	) u_stats (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clear(r.clear),
		.finish(r.finish),
		.sample_valid(collecting),
		.sample(press_data),
		.busy(st_busy),
		.done(st_done),
		.mean(st_mean),
		.variance(st_var)
	);

	always_comb
	begin
		logic relearn;
		logic low_dyn;
		logic steady;
		logic mean_moved;
		logic plugged;
		logic [31:0] rd;
		logic [PW-1:0] len;
		relearn = 1'h0;
		rd = '0;
		len = (r.phase == PH_DETECT) ? r.detect_len : r.learn_len;
		low_dyn = st_var < square(r.min_sd);
		steady = absdiff({{DW{1'h0}}, st_mean}, {{DW{1'h0}}, r.prev_mean}) <= {{DW{1'h0}}, r.mean_tol} &&
			absdiff(st_var, r.prev_var) <= r.var_tol;
		mean_moved = absdiff({{DW{1'h0}}, st_mean}, {{DW{1'h0}}, r.base_mean}) > {{DW{1'h0}}, r.mean_tol};
		plugged = (st_var < square(r.sd_lo)) || (r.dp && st_var > square(r.sd_hi));
		next_r = r;
		next_r.finish = 1'h0;
		next_r.clear = 1'h0;

		// One wait state: the answer is prepared in the first access cycle.
		if (psel && penable && !r.pready)
		begin
			next_r.pready = 1'h1;
			next_r.pslverr = 1'h0;
			case (paddr)
				ADDR_CTRL:
				begin
					rd[CTRL_ENABLE_BIT] = r.enable;
					rd[CTRL_AFFECT_BIT] = r.affect;
					rd[CTRL_DP_BIT] = r.dp;
				end
				ADDR_CMD: rd = '0;
				ADDR_LEARN_LEN: rd[PW-1:0] = r.learn_len;
				ADDR_DETECT_LEN: rd[PW-1:0] = r.detect_len;
				ADDR_MIN_SD: rd[DW-1:0] = r.min_sd;
				ADDR_SD_LO: rd[DW-1:0] = r.sd_lo;
				ADDR_SD_HI: rd[DW-1:0] = r.sd_hi;
				ADDR_MEAN_TOL: rd[DW-1:0] = r.mean_tol;
				ADDR_VAR_TOL: rd[2*DW-1:0] = r.var_tol;
				ADDR_STATUS:
				begin
					rd[STAT_DIAG_LSB +: 3] = r.diag;
					rd[STAT_ALERT_BIT] = r.plug_alert;
					rd[STAT_CALC_BIT] = r.calc;
					rd[STAT_PHASE_LSB +: 3] = r.phase;
				end
				default: next_r.pslverr = 1'h1;
			endcase
			next_r.prdata = pwrite ? '0 : rd;
		end
		else
		begin
			next_r.pready = 1'h0;
			next_r.pslverr = 1'h0;
			next_r.prdata = '0;
		end

		if (psel && penable && r.pready && pwrite && !r.pslverr)
		begin
			case (paddr)
				ADDR_CTRL:
				begin
					next_r.enable = pwdata[CTRL_ENABLE_BIT];
					next_r.affect = pwdata[CTRL_AFFECT_BIT];
					next_r.dp = pwdata[CTRL_DP_BIT];
				end
				ADDR_CMD: relearn = pwdata[CMD_RELEARN_BIT];
				ADDR_LEARN_LEN: next_r.learn_len = pwdata[PW-1:0];
				ADDR_DETECT_LEN: next_r.detect_len = pwdata[PW-1:0];
				ADDR_MIN_SD: next_r.min_sd = pwdata[DW-1:0];
				ADDR_SD_LO: next_r.sd_lo = pwdata[DW-1:0];
				ADDR_SD_HI: next_r.sd_hi = pwdata[DW-1:0];
				ADDR_MEAN_TOL: next_r.mean_tol = pwdata[DW-1:0];
				ADDR_VAR_TOL: next_r.var_tol = pwdata[2*DW-1:0];
				default: relearn = 1'h0;
			endcase
		end

		if (!next_r.enable)
		begin
			next_r.phase = PH_IDLE;
			next_r.diag = DG_DISABLED;
			next_r.plug_alert = 1'h0;
			next_r.calc = 1'h0;
			next_r.tcount = '0;
		end
		else if (relearn || (!r.enable && !st_busy))
		begin
			next_r.phase = PH_LEARN;
			next_r.diag = DG_LEARNING;
			next_r.plug_alert = 1'h0;
			next_r.calc = 1'h0;
			next_r.tcount = '0;
			next_r.clear = 1'h1;
		end
		else
		begin
			case (r.phase)
				PH_LEARN, PH_VERIFY, PH_DETECT:
				begin
					if (!r.calc && !r.clear)
					begin
						if (tick)
						begin
							if (r.tcount + PW'(1) >= len)
							begin
								next_r.tcount = '0;
								next_r.finish = 1'h1;
								next_r.calc = 1'h1;
							end
							else
								next_r.tcount = r.tcount + PW'(1);
						end
					end
					else if (r.calc && st_done)
					begin
						next_r.calc = 1'h0;
						next_r.clear = 1'h1;
						next_r.prev_mean = st_mean;
						next_r.prev_var = st_var;
						if (r.phase != PH_DETECT && low_dyn)
						begin
							next_r.phase = PH_HALT_DYN;
							next_r.diag = DG_INSUFFICIENT;
						end
						else if (r.phase == PH_LEARN)
						begin
							next_r.phase = PH_VERIFY;
							next_r.diag = DG_VERIFYING;
						end
						else if (r.phase == PH_VERIFY)
						begin
							if (steady)
							begin
								next_r.phase = PH_DETECT;
								next_r.diag = DG_OK;
								next_r.base_mean = st_mean;
								next_r.base_var = st_var;
							end
							else
								next_r.phase = PH_VERIFY;
						end
						else if (mean_moved)
						begin
							next_r.phase = PH_LEARN;
							next_r.diag = DG_LEARNING;
						end
						else if (plugged)
						begin
							next_r.phase = PH_HALT_PLUG;
							next_r.diag = DG_LINES_PLUGGED;
							next_r.plug_alert = 1'h1;
						end
						else
							next_r.diag = DG_OK;
					end
				end
				PH_HALT_DYN, PH_HALT_PLUG: next_r.phase = r.phase;
				default:
				begin
					next_r.phase = PH_IDLE;
					next_r.diag = DG_DISABLED;
				end
			endcase
		end

		// The quality override follows the alert with one cycle of delay on the pressure path.
		next_r.qual_out = (r.affect && r.plug_alert) ? QUAL_UNCERTAIN : press_quality;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.phase <= PH_IDLE;
			r.diag <= DG_DISABLED;
			r.learn_len <= PW'(LEARN_TICKS);
			r.detect_len <= PW'(DETECT_TICKS);
			r.min_sd <= DW'(MIN_SD_RST);
			r.sd_lo <= DW'(SD_LO_RST);
			r.sd_hi <= DW'(SD_HI_RST);
			r.mean_tol <= DW'(MEAN_TOL_RST);
			r.var_tol <= (2*DW)'(VAR_TOL_RST);
		end
		else if (ce)
			r <= next_r;
	end

	assign pready = r.pready;
	assign prdata = r.prdata;
	assign pslverr = r.pslverr;
	assign press_quality_out = r.qual_out;
	assign plug_alert = r.plug_alert;
	assign diag_status = r.diag;

endmodule : ilpd_top

// ===== dv/ilpd_properties.sv
module ilpd_checker
	import ilpd_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Results.
	input wire logic [1:0] press_quality,
	input wire logic [1:0] press_quality_out,
	input wire logic plug_alert,
	input wire logic [2:0] diag_status
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence apb_req_s;
		psel && !penable && ce ##1 psel && penable && ce;
	endsequence

	sequence bus_quiet_s;
		!psel [*3];
	endsequence

	apb_ready_a: assert property (apb_req_s |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata leaks");
	verify_entry_a: assert property ($changed(diag_status) && diag_status == 3'h2 |->
		$past(diag_status) == 3'h1) else $error("bad verify entry");
	detect_entry_a: assert property ($changed(diag_status) && diag_status == 3'h3 |->
		$past(diag_status) == 3'h2) else $error("bad detect entry");
	dyn_entry_a: assert property ($changed(diag_status) && diag_status == 3'h4 |->
		$past(diag_status) inside {3'h1, 3'h2}) else $error("bad halt entry");
	plug_entry_a: assert property ($changed(diag_status) && diag_status == 3'h5 |->
		$past(diag_status) == 3'h3) else $error("bad plug entry");
	halt_hold_a: assert property ((bus_quiet_s ##0 diag_status == 3'h4) |=>
		diag_status == 3'h4) else $error("halt left");
	alert_status_a: assert property (plug_alert |-> diag_status == 3'h5) else $error("alert mismatch");
	quality_pass_a: assert property ($past(presetn) && !$past(plug_alert) |->
		press_quality_out == $past(press_quality)) else $error("quality altered");
endmodule : ilpd_checker

bind ilpd_top ilpd_checker i_chk (
	.pclk(pclk),
	.presetn(presetn),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.prdata(prdata),
	.pslverr(pslverr),
	.press_quality(press_quality),
	.press_quality_out(press_quality_out),
	.plug_alert(plug_alert),
	.diag_status(diag_status)
);

// ===== dv/ilpd_src.sv
module ilpd_src
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Signal shape.
	input wire logic [15:0] amp,
	input wire logic [15:0] base,
	// Pressure stream.
	output logic press_valid,
	output logic [15:0] press_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase;
	logic up;

	// Alternating samples give a mean of base and a deviation of amp.
	// Between strobes the data is inverted so nothing stale looks valid.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase <= 2'h0;
			up <= 1'b0;
			press_valid <= 1'b0;
			press_data <= 16'h0;
		end
		else
		begin
			phase <= phase + 2'h1;
			press_valid <= (phase == 2'h3);
			if (phase == 2'h3)
			begin
				up <= !up;
				press_data <= up ? base + amp : base - amp;
			end
			else
				press_data <= ~press_data;
		end
	end
endmodule : ilpd_src

// ===== dv/tb_impulse_line_plug_detector.sv
module tb_impulse_line_plug_detector
	import ilpd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic tick = 1'b0;
	logic [15:0] amp = 16'h0;
	logic [15:0] base = 16'h03E8;
	logic press_valid, pready, pslverr, plug_alert;
	logic [15:0] press_data;
	logic [31:0] prdata, rd;
	logic [1:0] press_quality_out;
	logic [2:0] diag_status;
	logic er;
	int n_mismatch = 0;
	int cmp_count = 0;
	int tick_cnt = 0;

	ilpd_top i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .tick(tick), .press_valid(press_valid), .press_data(press_data),
		.press_quality(2'h2), .press_quality_out(press_quality_out), .plug_alert(plug_alert),
		.diag_status(diag_status));
	ilpd_src i_src (.pclk(pclk), .presetn(presetn), .amp(amp), .base(base),
		.press_valid(press_valid), .press_data(press_data));

	always #4 pclk = ~pclk;

	// A short tick spacing keeps each period to a few hundred cycles.
	always @(posedge pclk)
	begin
		tick_cnt <= (tick_cnt == 99) ? 0 : tick_cnt + 1;
		tick <= (tick_cnt == 99);
	end

	task check(input string name, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("register", rd, exp);
	endtask : rd_chk

	task wait_diag(input logic [2:0] d);
		int n;
		n = 0;
		while (diag_status !== d && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		check("diag_status", {29'h0, diag_status}, {29'h0, d});
	endtask : wait_diag

	task close_out;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (60000) @(posedge pclk);
		n_mismatch++;
		close_out();
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_LEARN_LEN, 32'(LEARN_TICKS));
		rd_chk(ADDR_DETECT_LEN, 32'(DETECT_TICKS));
		rd_chk(ADDR_MIN_SD, 32'(MIN_SD_RST));
		rd_chk(ADDR_SD_LO, 32'(SD_LO_RST));
		rd_chk(ADDR_SD_HI, 32'(SD_HI_RST));
		rd_chk(ADDR_MEAN_TOL, 32'(MEAN_TOL_RST));
		rd_chk(ADDR_VAR_TOL, 32'(VAR_TOL_RST));
		rd_chk(ADDR_CMD, 32'h0);
		rd_chk(8'h28, 32'h0);
		check("pslverr", {31'h0, er}, 32'h1);
		apb(1'b1, ADDR_LEARN_LEN, 32'h4);
		apb(1'b1, ADDR_DETECT_LEN, 32'h3);
		rd_chk(ADDR_LEARN_LEN, 32'h4);
		// Flat input: learning must halt for lack of noise.
		apb(1'b1, ADDR_CTRL, 32'h3);
		wait_diag(3'h1);
		wait_diag(3'h4);
		repeat (600) @(posedge pclk);
		check("halted", {29'h0, diag_status}, 32'h4);
		amp <= 16'h0014;
		apb(1'b1, ADDR_CMD, 32'h1);
		wait_diag(3'h1);
		wait_diag(3'h2);
		wait_diag(3'h3);
		check("alert idle", {31'h0, plug_alert}, 32'h0);
		amp <= 16'h0001;
		wait_diag(3'h5);
		check("alert", {31'h0, plug_alert}, 32'h1);
		repeat (2) @(posedge pclk);
		check("quality", {30'h0, press_quality_out}, {30'h0, QUAL_UNCERTAIN});
		amp <= 16'h0014;
		apb(1'b1, ADDR_CMD, 32'h1);
		wait_diag(3'h1);
		wait_diag(3'h3);
		base <= 16'h07D0;
		wait_diag(3'h1);
		close_out();
	end
endmodule : tb_impulse_line_plug_detector
